// File: core/vsr_defs.vh
// constants for the per-core video serializer: field positions, widths, reset values
`ifndef VSR_DEFS_VH
`define VSR_DEFS_VH

// ==========================================
// video_configuration fields
`define VSR_CFG_MODE_HI 30
`define VSR_CFG_MODE_LO 29
`define VSR_CFG_DEPTH_BIT 28
`define VSR_CFG_BCAST_CHROMA_BIT 27
`define VSR_CFG_BBAND_CHROMA_BIT 26
`define VSR_CFG_AURAL_HI 25
`define VSR_CFG_AURAL_LO 23
`define VSR_CFG_GROUP_HI 11
`define VSR_CFG_GROUP_LO 9
`define VSR_CFG_MASK_HI 7
`define VSR_CFG_MASK_LO 0
// writable bits; the rest read as zero
`define VSR_CFG_WMASK 32'h7f800eff
`define VSR_CFG_RESET 32'h00000000

// ==========================================
// video_rate_scale fields
`define VSR_SCL_PIXEL_HI 19
`define VSR_SCL_PIXEL_LO 12
`define VSR_SCL_FRAME_HI 11
`define VSR_SCL_FRAME_LO 0
`define VSR_SCL_WMASK 32'h000fffff
`define VSR_SCL_RESET 32'h00000000

// ==========================================
// output modes
`define VSR_MODE_OFF 2'h0
`define VSR_MODE_PARALLEL 2'h1
`define VSR_MODE_COMP_BCAST_HIGH 2'h2
`define VSR_MODE_COMP_BBAND_HIGH 2'h3

// ==========================================
// timing: zero in a period field means the full range
`define VSR_PIXEL_ZERO_LEN 9'h100
`define VSR_FRAME_ZERO_LEN 13'h1000
`define VSR_LAST_SHIFT_2BIT 5'h0f
`define VSR_LAST_SHIFT_1BIT 5'h1f
`define VSR_GROUP_LAST 3'h3

`endif

// File: core/vsr_fifo.v
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps

module vsr_fifo #(
  parameter WIDTH = 64,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire mclk,
  input wire arst_n,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);

  // ==========================================
  // storage and pointers
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] count;
  wire push;
  wire pop;

  assign in_ready = (count != DEPTH[AW:0]);
  assign out_valid = (count != {(AW+1){1'b0}});
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign out_data = mem[rd_ptr];

  always @(posedge mclk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end

endmodule // vsr_fifo

// File: core/vsr_video_serializer.v
// per-core video serializer: registers, frame/pixel timing, colour pick, pin steering
`timescale 1ns/1ps
`include "vsr_defs.vh"

module vsr_video_serializer #(
  parameter FIFO_DEPTH = 8,
  parameter FIFO_AW = 3
) (
  input wire mclk,
  input wire arst_n,
  input wire pll_clk,
  input wire [7:0] aural_pll,
  input wire cfg_wr,
  input wire scl_wr,
  input wire [31:0] wr_data,
  output reg [31:0] video_configuration,
  output reg [31:0] video_rate_scale,
  input wire hand_active,
  input wire [31:0] hand_colors,
  input wire [31:0] hand_pixels,
  output wire hand_done,
  output reg frame_load,
  output reg [31:0] vid_out,
  output reg [31:0] vid_oe
);

  // ==========================================
  // register file
  // the core's own register writes; no reset value is defined, so zero means disabled
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      video_configuration <= `VSR_CFG_RESET;
      video_rate_scale <= `VSR_SCL_RESET;
    end else begin
      if (cfg_wr) begin
        video_configuration <= wr_data & `VSR_CFG_WMASK;
      end
      if (scl_wr) begin
        video_rate_scale <= wr_data & `VSR_SCL_WMASK;
      end
    end
  end

  wire [1:0] output_mode_field;
  wire colour_depth_bit;
  wire broadcast_colour_enable;
  wire baseband_colour_enable;
  wire [2:0] audio_source_select;
  wire [2:0] pin_group_select;
  wire [7:0] pin_output_mask;
  wire [7:0] pixel_period;
  wire [11:0] frame_period;

  assign output_mode_field = video_configuration[`VSR_CFG_MODE_HI:`VSR_CFG_MODE_LO];
  assign colour_depth_bit = video_configuration[`VSR_CFG_DEPTH_BIT];
  assign broadcast_colour_enable = video_configuration[`VSR_CFG_BCAST_CHROMA_BIT];
  assign baseband_colour_enable = video_configuration[`VSR_CFG_BBAND_CHROMA_BIT];
  assign audio_source_select = video_configuration[`VSR_CFG_AURAL_HI:`VSR_CFG_AURAL_LO];
  assign pin_group_select = video_configuration[`VSR_CFG_GROUP_HI:`VSR_CFG_GROUP_LO];
  assign pin_output_mask = video_configuration[`VSR_CFG_MASK_HI:`VSR_CFG_MASK_LO];
  assign pixel_period = video_rate_scale[`VSR_SCL_PIXEL_HI:`VSR_SCL_PIXEL_LO];
  assign frame_period = video_rate_scale[`VSR_SCL_FRAME_HI:`VSR_SCL_FRAME_LO];

  // ==========================================
  // input synchronisers
  // the pll clock and other cores' pll outputs are not on mclk
  reg pll_s1;
  reg pll_s2;
  reg pll_s3;
  reg [7:0] aur_s1;
  reg [7:0] aur_s2;

  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pll_s1 <= 1'b0;
      pll_s2 <= 1'b0;
      pll_s3 <= 1'b0;
      aur_s1 <= 8'h00;
      aur_s2 <= 8'h00;
    end else begin
      pll_s1 <= pll_clk;
      pll_s2 <= pll_s1;
      pll_s3 <= pll_s2;
      aur_s1 <= aural_pll;
      aur_s2 <= aur_s1;
    end
  end

  // one enable pulse per rising pll edge; pll must stay under half of mclk
  wire pll_tick;
  assign pll_tick = pll_s2 & ~pll_s3;

  wire aural_level;
  assign aural_level = aur_s2[audio_source_select];

  // ==========================================
  // period lengths
  wire [8:0] pixel_len;
  wire [12:0] frame_len;

  assign pixel_len = (pixel_period == 8'h00) ? `VSR_PIXEL_ZERO_LEN :
                     {1'b0, pixel_period};
  assign frame_len = (frame_period == 12'h000) ? `VSR_FRAME_ZERO_LEN :
                     {1'b0, frame_period};

  // ==========================================
  // frame boundary and handoff
  reg [12:0] frame_cnt;
  wire frame_end;
  wire fetch;
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire fifo_pop;
  wire [63:0] fifo_out_data;

  assign frame_end = pll_tick && (frame_cnt == frame_len - 13'h0001);
  // a full buffer holds the boundary back instead of losing a word
  assign fetch = frame_end & fifo_in_ready;
  // the core is released only at a boundary, so a dead pll never frees it
  assign hand_done = fetch & hand_active;

  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      frame_cnt <= 13'h0000;
    end else if (fetch) begin
      frame_cnt <= 13'h0000;
    end else if (pll_tick && !frame_end) begin
      // a shortened frame period may leave the count past its end; wrap it
      if (frame_cnt >= frame_len - 13'h0001) begin
        frame_cnt <= 13'h0000;
      end else begin
        frame_cnt <= frame_cnt + 13'h0001;
      end
    end
  end

  // buses are captured whether or not a handoff is pending
  vsr_fifo #(
    .WIDTH(64),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .mclk(mclk),
    .arst_n(arst_n),
    .in_valid(frame_end),
    .in_ready(fifo_in_ready),
    .in_data({hand_colors, hand_pixels}),
    .out_valid(fifo_out_valid),
    .out_ready(pll_tick),
    .out_data(fifo_out_data)
  );

  assign fifo_pop = fifo_out_valid & pll_tick;

  // ==========================================
  // pixel shifter
  reg [31:0] pixel_shift;
  reg [31:0] colour_word;
  reg [8:0] pixel_cnt;
  reg [4:0] shift_cnt;
  wire [4:0] last_shift;
  wire pixel_end;

  assign last_shift = colour_depth_bit ? `VSR_LAST_SHIFT_2BIT : `VSR_LAST_SHIFT_1BIT;
  assign pixel_end = (pixel_cnt == pixel_len - 9'h001);

  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pixel_shift <= 32'h00000000;
      colour_word <= 32'h00000000;
      pixel_cnt <= 9'h000;
      shift_cnt <= 5'h00;
      frame_load <= 1'b0;
    end else begin
      frame_load <= fifo_pop;
      if (fifo_pop) begin
        pixel_shift <= fifo_out_data[31:0];
        colour_word <= fifo_out_data[63:32];
        pixel_cnt <= 9'h000;
        shift_cnt <= 5'h00;
      end else if (pll_tick) begin
        if (pixel_end || pixel_cnt >= pixel_len) begin
          pixel_cnt <= 9'h000;
          // after the last pixel the shifter freezes, repeating the top pixel
          if (shift_cnt < last_shift) begin
            shift_cnt <= shift_cnt + 5'h01;
            if (colour_depth_bit) begin
              pixel_shift <= {2'b00, pixel_shift[31:2]};
            end else begin
              pixel_shift <= {1'b0, pixel_shift[31:1]};
            end
          end
        end else begin
          pixel_cnt <= pixel_cnt + 9'h001;
        end
      end
    end
  end

  // ==========================================
  // colour pick
  wire [1:0] colour_index;
  reg [7:0] colour_byte;

  assign colour_index = colour_depth_bit ? pixel_shift[1:0] : {1'b0, pixel_shift[0]};

  always @* begin
    case (colour_index)
      2'h0: colour_byte = colour_word[7:0];
      2'h1: colour_byte = colour_word[15:8];
      2'h2: colour_byte = colour_word[23:16];
      2'h3: colour_byte = colour_word[31:24];
      default: colour_byte = 8'h00;
    endcase
  end

  // ==========================================
  // composite nibbles
  // simplified digital stand-in for the analog modulator:
  // luma in bits 2:0 (broadcast: bits 2:1, aural in bit 0), modulation flag in bit 3, phase is not rendered
  wire [3:0] bband_nibble;
  wire [3:0] bcast_nibble;

  assign bband_nibble = {colour_byte[3] & baseband_colour_enable, colour_byte[2:0]};
  assign bcast_nibble = {colour_byte[3] & broadcast_colour_enable, colour_byte[2:1],
                         aural_level};

  reg [7:0] group_byte;
  always @* begin
    case (output_mode_field)
      `VSR_MODE_PARALLEL: group_byte = colour_byte;
      `VSR_MODE_COMP_BCAST_HIGH: group_byte = {bcast_nibble, bband_nibble};
      `VSR_MODE_COMP_BBAND_HIGH: group_byte = {bband_nibble, bcast_nibble};
      default: group_byte = 8'h00;
    endcase
  end

  // ==========================================
  // pin steering
  wire video_on;
  wire [7:0] lane_oe;
  assign video_on = (output_mode_field != `VSR_MODE_OFF) &&
                    (pin_group_select <= `VSR_GROUP_LAST);
  assign lane_oe = video_on ? pin_output_mask : 8'h00;

  reg [31:0] next_vid_out;
  reg [31:0] next_vid_oe;
  always @* begin
    next_vid_out = 32'h00000000;
    next_vid_oe = 32'h00000000;
    case (pin_group_select[1:0])
      2'h0: begin
        next_vid_out[7:0] = group_byte & lane_oe;
        next_vid_oe[7:0] = lane_oe;
      end
      2'h1: begin
        next_vid_out[15:8] = group_byte & lane_oe;
        next_vid_oe[15:8] = lane_oe;
      end
      2'h2: begin
        next_vid_out[23:16] = group_byte & lane_oe;
        next_vid_oe[23:16] = lane_oe;
      end
      2'h3: begin
        next_vid_out[31:24] = group_byte & lane_oe;
        next_vid_oe[31:24] = lane_oe;
      end
      default: begin
        next_vid_out = 32'h00000000;
        next_vid_oe = 32'h00000000;
      end
    endcase
  end

  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      vid_out <= 32'h00000000;
      vid_oe <= 32'h00000000;
    end else begin
      vid_out <= next_vid_out;
      vid_oe <= next_vid_oe;
    end
  end

endmodule // vsr_video_serializer

// File: dv/vsr_chk.sv
// port checker for the video serializer, bound to its top
`timescale 1ns/1ps
`include "vsr_defs.vh"
module vsr_chk (
  input wire mclk,
  input wire arst_n,
  input wire pll_clk,
  input wire cfg_wr,
  input wire [31:0] wr_data,
  input wire [31:0] video_configuration,
  input wire hand_active,
  input wire hand_done,
  input wire frame_load,
  input wire [31:0] vid_out,
  input wire [31:0] vid_oe
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  // ==========================================
  // expected enables from the live configuration
  wire [2:0] grp = video_configuration[11:9];
  wire off = video_configuration[30:29] == 2'h0 || grp[2];
  wire [31:0] oe_exp = off ? 32'h0 : {24'h0, video_configuration[7:0]} << (8 * grp[1:0]);
  // ==========================================
  // assertions
  property p_cfg_wr;
    cfg_wr |=> video_configuration == ($past(wr_data) & `VSR_CFG_WMASK);
  endproperty
  a_cfg_wr: assert property (p_cfg_wr) else $error("config write lost");
  property p_cfg_hold;
    !cfg_wr |=> $stable(video_configuration);
  endproperty
  a_cfg_hold: assert property (p_cfg_hold) else $error("config moved");
  property p_off;
    (video_configuration[30:29] == 2'h0)[*2] |-> vid_oe == 32'h0 && vid_out == 32'h0;
  endproperty
  a_off: assert property (p_off) else $error("output while off");
  property p_oe_map;
    $stable(video_configuration)[*3] |-> vid_oe == oe_exp;
  endproperty
  a_oe_map: assert property (p_oe_map) else $error("enables wrong");
  property p_out_mask;
    (vid_out & ~vid_oe) == 32'h0;
  endproperty
  a_out_mask: assert property (p_out_mask) else $error("data on idle pin");
  property p_done_act;
    hand_done |-> hand_active ##1 !hand_done[*3];
  endproperty
  a_done_act: assert property (p_done_act) else $error("release without wait");
  property p_no_pll;
    $stable(pll_clk)[*8] |-> !hand_done && !frame_load;
  endproperty
  a_no_pll: assert property (p_no_pll) else $error("frame without pll");
  property p_load_pulse;
    frame_load |=> !frame_load[*3];
  endproperty
  a_load_pulse: assert property (p_load_pulse) else $error("load too long");
endmodule // vsr_chk

bind vsr_video_serializer vsr_chk i_vsr_chk (
  .mclk(mclk), .arst_n(arst_n), .pll_clk(pll_clk), .cfg_wr(cfg_wr), .wr_data(wr_data),
  .video_configuration(video_configuration), .hand_active(hand_active),
  .hand_done(hand_done), .frame_load(frame_load), .vid_out(vid_out), .vid_oe(vid_oe)
);

// File: dv/vsr_pll_src.sv
// counter-A clock and aural sources facing the serializer
`timescale 1ns/1ps
module vsr_pll_src #(
  parameter AURAL_PAT = 8'h5a
) (
  input wire run,
  output reg pll_clk,
  output wire [7:0] aural_pll
);
  // other cores modulate their audio themselves; levels suffice here
  assign aural_pll = AURAL_PAT;
  // odd offset keeps the pll edges away from the mclk edges
  initial begin
    pll_clk = 1'b0;
    #1.3;
    forever begin
      #10;
      pll_clk = run ? ~pll_clk : 1'b0;
    end
  end
endmodule // vsr_pll_src

// File: dv/vsr_video_serializer_tb_top.sv
// self-checking bench for the per-core video serializer
`timescale 1ns/1ps
`include "vsr_defs.vh"
module vsr_video_serializer_tb_top;
  localparam logic [7:0] AURAL = 8'h5a;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic cfg_wr = 1'b0;
  logic scl_wr = 1'b0;
  logic [31:0] wr_data = 32'h0;
  logic hand_active = 1'b0;
  logic [31:0] hand_colors = 32'h0;
  logic [31:0] hand_pixels = 32'h0;
  logic run = 1'b0;
  wire pll_clk, hand_done, frame_load;
  wire [7:0] aural_pll;
  wire [31:0] video_configuration, video_rate_scale, vid_out, vid_oe;
  int fails = 0;
  int checked = 0;
  int cyc = 0;
  logic [7:0] last = 8'h0;
  logic [7:0] seq [$];
  int stamp [$];

  always #2.5 mclk = ~mclk;

  vsr_pll_src #(.AURAL_PAT(AURAL)) i_vsr_pll_src (
    .run(run), .pll_clk(pll_clk), .aural_pll(aural_pll)
  );
  vsr_video_serializer i_vsr_video_serializer (
    .mclk(mclk), .arst_n(arst_n), .pll_clk(pll_clk), .aural_pll(aural_pll),
    .cfg_wr(cfg_wr), .scl_wr(scl_wr), .wr_data(wr_data),
    .video_configuration(video_configuration), .video_rate_scale(video_rate_scale),
    .hand_active(hand_active), .hand_colors(hand_colors), .hand_pixels(hand_pixels),
    .hand_done(hand_done), .frame_load(frame_load), .vid_out(vid_out), .vid_oe(vid_oe)
  );

  // ==========================================
  // monitor: sampled on the falling edge, clear of the launch edge
  always @(negedge mclk) begin
    cyc++;
    if (vid_out[7:0] !== last) begin
      seq.push_back(vid_out[7:0]);
      stamp.push_back(cyc);
    end
    last = vid_out[7:0];
    if (cyc == 80000) begin
      fails++;
      end_sim();
    end
  end

  // ==========================================
  // shared tasks
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_sim();
    $display("fails %0d checked %0d", fails, checked);
    if (fails == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic wr(input logic cfg, input logic [31:0] d);
    @(posedge mclk);
    cfg_wr <= cfg;
    scl_wr <= !cfg;
    wr_data <= d;
    @(posedge mclk);
    cfg_wr <= 1'b0;
    scl_wr <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic wait_load();
    int n;
    n = 0;
    @(negedge mclk);
    while (frame_load !== 1'b1 && n < 40000) begin
      @(negedge mclk);
      n++;
    end
    chk("frame_load", frame_load, 32'h1);
  endtask

  task automatic count_done(input int cycles, output int seen);
    seen = 0;
    repeat (cycles) begin
      @(negedge mclk);
      seen += (hand_done === 1'b1);
    end
  endtask

  // ==========================================
  // scenarios
  task automatic t_regs();
    chk("cfg reset", video_configuration, `VSR_CFG_RESET);
    chk("scl reset", video_rate_scale, `VSR_SCL_RESET);
    wr(1'b1, 32'hffffffff);
    wr(1'b0, 32'hffffffff);
    chk("cfg rw", video_configuration, `VSR_CFG_WMASK);
    chk("scl rw", video_rate_scale, `VSR_SCL_WMASK);
    wr(1'b1, 32'h0);
  endtask

  task automatic t_pattern(input logic d, input logic [31:0] pix, input logic [31:0] col,
                           input logic [7:0] p, input logic [11:0] f);
    int n, pl, fl, idx, i, el;
    n = d ? 16 : 32;
    pl = (p == 8'h0) ? 256 : p;
    fl = (f == 12'h0) ? 4096 : f;
    @(posedge mclk);
    hand_pixels <= pix;
    hand_colors <= col;
    wr(1'b0, {12'h0, p, f});
    wr(1'b1, {1'b0, 2'h1, d, 20'h0, 8'hff});
    wait_load();
    wait_load();
    seq.delete();
    stamp.delete();
    i = 0;
    while (seq.size() <= n && i < 40000) begin
      @(negedge mclk);
      i++;
    end
    for (i = 0; i < n; i++) begin
      idx = d ? (pix >> (2 * i)) & 3 : (pix >> i) & 1;
      chk("pixel", seq[i], col[8 * idx +: 8]);
      // one pll period is four mclk cycles
      el = 4 * ((i == n - 1) ? fl - (n - 1) * pl : pl);
      chk("period", stamp[i + 1] - stamp[i], el);
    end
  endtask

  task automatic t_stall();
    int s;
    @(posedge mclk);
    hand_active <= 1'b1;
    count_done(600, s);
    chk("release", s != 0, 32'h1);
    @(posedge mclk);
    run <= 1'b0;
    // a pll edge already in the synchroniser may still release once
    repeat (8) @(negedge mclk);
    count_done(600, s);
    chk("stall", s, 32'h0);
    @(posedge mclk);
    run <= 1'b1;
    count_done(600, s);
    chk("restart", s != 0, 32'h1);
    @(posedge mclk);
    hand_active <= 1'b0;
  endtask

  // core never waits here, so colours come from the idle buses
  task automatic t_pins();
    int i;
    logic [1:0] m;
    logic [2:0] g, k;
    logic [3:0] bb, bc;
    logic [7:0] mk, v, oe;
    @(posedge mclk);
    hand_colors <= 32'h0f0f0f0f;
    wait_load();
    wait_load();
    for (i = 0; i < 32; i++) begin
      m = i[1:0];
      g = i[4:2];
      k = i[2:0] + i[4:3];
      mk = {i[4:1], ~i[3:0]};
      bb = {i[3], 3'h7};
      bc = {i[2], 2'h3, AURAL[k]};
      v = (m == 2'h1) ? 8'h0f : (m == 2'h2) ? {bc, bb} : {bb, bc};
      oe = (m == 2'h0 || g > 3'h3) ? 8'h0 : mk;
      wr(1'b1, {1'b0, m, 1'b0, i[2], i[3], k, 11'h0, g, 1'b0, mk});
      repeat (2) @(negedge mclk);
      chk("pins", vid_out, {24'h0, v & oe} << (8 * g[1:0]));
      chk("enables", vid_oe, {24'h0, oe} << (8 * g[1:0]));
    end
  endtask

  initial begin
    repeat (4) @(posedge mclk);
    arst_n <= 1'b1;
    t_regs();
    @(posedge mclk);
    run <= 1'b1;
    t_pattern(1'b1, 32'he4e4e4e4, 32'h44332211, 8'h1, 12'h014);
    t_pattern(1'b0, 32'h55555555, 32'h0000bbaa, 8'h2, 12'h040);
    t_stall();
    t_pins();
    t_pattern(1'b1, 32'he4e4e4e4, 32'h44332211, 8'h0, 12'h000);
    end_sim();
  end
endmodule // vsr_video_serializer_tb_top
